// ===== verilog/btc_timer.sv
// byte timer with high and low phase capture and waveform load
//
// Functional notes
// (RULE1) enable bit starts, stops, reads running state
// (RULE2) single pass halts, otherwise modulo-n repeats
// (RULE3) clock select divides by 1, 2, 4, 8
// (RULE4) timeout flag set by hardware, write-1 clears
// (RULE5) counter interrupt mask gates timeout request
// (RULE6) capture interrupt mask gates capture request
// (RULE7) route bit puts timer output on pin
// (RULE8) high capture holds input-high count
// (RULE9) low capture holds input-low count
// (RULE10) capture registers read-only, reset zero
// (RULE11) high load sets output high duration
// (RULE12) shared mode bit: transmit or capture
// (RULE13) low load sets output low duration
// (RULE14) transmit alternates loads, toggles, flags expiry
module btc_timer
    import btc_pkg::*;
(
    // clock, reset, enable
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire logic                        ce,
    // avalon-mm slave
    input  wire logic [btc_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [btc_pkg::BUS_W-1:0]   avs_writedata,
    output logic      [btc_pkg::BUS_W-1:0]   avs_readdata,
    output logic                             avs_waitrequest,
    // measured pulse input pin
    input  wire logic                        pulse_in,
    // general purpose drive of the shared pin
    input  wire logic                        gpio_out,
    input  wire logic                        gpio_oe,
    // pin and timer outputs
    output logic                             pin_out,
    output logic                             pin_oe,
    output logic                             byte_timer_output,
    // interrupt
    output logic                             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    btc_tick_if tif ();

    logic [DATA_W-1:0] byte_timer_control;
    logic [DATA_W-1:0] shared_timer_control;
    logic [DATA_W-1:0] high_duration_load;
    logic [DATA_W-1:0] low_duration_load;
    logic [DATA_W-1:0] high_phase_capture;
    logic [DATA_W-1:0] low_phase_capture;
    logic [INT_W-1:0]  int_status;
    logic [INT_W-1:0]  int_mask;
    btc_state_t        state;
    logic [DATA_W-1:0] count;
    logic              tmr_out;
    logic              in_meta;
    logic              in_sync;
    logic              in_last;

    logic [IDX_W-1:0]  reg_idx;
    logic              wr_fire;
    logic              rd_fire;
    logic              wr_ctrl;
    logic              wr_shared;
    logic              wr_low_load;
    logic              wr_high_load;
    logic              wr_int_mask;
    logic              rd_status;
    logic [DATA_W-1:0] wbyte;
    logic [DATA_W-1:0] rd_byte;
    logic              mode_demod;
    logic              single_pass;
    logic              start_req;
    logic              stop_req;
    logic              in_edge;
    logic              expire;
    logic              timeout_ev;
    logic              capture_ev;
    logic [INT_W-1:0]  events;
    logic [INT_W-1:0]  gate;
    logic [INT_W-1:0]  status_ack;
    logic              running;
    logic              next_irq;
    btc_state_t        next_state;
    logic [DATA_W-1:0] next_count;
    logic              next_out;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    assign reg_idx      = avs_address[ADDR_W-1:2];
    assign wr_fire      = avs_write && !avs_waitrequest;
    assign rd_fire      = avs_read && !avs_waitrequest;
    assign wbyte        = avs_writedata[DATA_W-1:0];
    assign wr_ctrl      = wr_fire && (reg_idx == IDX_CTRL);
    assign wr_shared    = wr_fire && (reg_idx == IDX_SHARED);
    assign wr_low_load  = wr_fire && (reg_idx == IDX_LOW_LOAD);
    assign wr_high_load = wr_fire && (reg_idx == IDX_HIGH_LOAD);
    assign wr_int_mask  = wr_fire && (reg_idx == IDX_INT_MASK);
    assign rd_status    = rd_fire && (reg_idx == IDX_INT_STATUS);

    assign running = (state == BTC_RUNNING);

    // read mux, unmapped reads return zero, capture writes are ignored
    assign rd_byte =
        (reg_idx == IDX_CTRL)       ? {running, byte_timer_control[CTRL_ENABLE-1:0]} : // RULE1
        (reg_idx == IDX_SHARED)     ? shared_timer_control :
        (reg_idx == IDX_LOW_LOAD)   ? low_duration_load :
        (reg_idx == IDX_HIGH_LOAD)  ? high_duration_load : // RULE11
        (reg_idx == IDX_LOW_CAP)    ? low_phase_capture : // RULE10
        (reg_idx == IDX_HIGH_CAP)   ? high_phase_capture : // RULE10
        (reg_idx == IDX_INT_STATUS) ? {{(DATA_W-INT_W){1'b0}}, int_status} :
        (reg_idx == IDX_INT_MASK)   ? {{(DATA_W-INT_W){1'b0}}, int_mask} :
                                      8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake

    // one wait cycle, then the answer for exactly one cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else if (ce) begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            avs_readdata    <= {{(BUS_W-DATA_W){1'b0}}, rd_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers

    assign mode_demod  = shared_timer_control[SHARED_MODE]; // RULE12
    assign single_pass = byte_timer_control[CTRL_SINGLE];
    assign start_req   = wr_ctrl && wbyte[CTRL_ENABLE] && !running; // RULE1
    assign stop_req    = wr_ctrl && !wbyte[CTRL_ENABLE]; // RULE1

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            byte_timer_control <= CTRL_RST;
        end else if (ce) begin
            if (wr_ctrl) begin
                byte_timer_control[CTRL_ENABLE-1:CTRL_TIMEOUT+1] <= wbyte[CTRL_SINGLE]; // RULE2
                byte_timer_control[CTRL_CLK_HI:0] <= wbyte[CTRL_CLK_HI:0]; // RULE3
            end
            byte_timer_control[CTRL_ENABLE] <= 1'b0;
            // hardware set wins over write-one clear
            byte_timer_control[CTRL_TIMEOUT] <= timeout_ev ||
                (byte_timer_control[CTRL_TIMEOUT] && !(wr_ctrl && wbyte[CTRL_TIMEOUT])); // RULE4
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shared_timer_control <= SHARED_RST;
            high_duration_load   <= LOAD_RST;
            low_duration_load    <= LOAD_RST;
            int_mask             <= INT_RST;
        end else if (ce) begin
            if (wr_shared) begin
                shared_timer_control <= wbyte; // RULE12
            end
            if (wr_high_load) begin
                high_duration_load <= wbyte; // RULE11
            end
            if (wr_low_load) begin
                low_duration_load <= wbyte; // RULE13
            end
            if (wr_int_mask) begin
                int_mask <= wbyte[INT_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pulse input synchroniser

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in_meta <= 1'b0;
            in_sync <= 1'b0;
            in_last <= 1'b0;
        end else if (ce) begin
            in_meta <= pulse_in;
            in_sync <= in_meta;
            in_last <= in_sync;
        end
    end

    assign in_edge = in_sync != in_last;

    ////////////////////////////////////////////////////////////////////////////
    // prescaler

    assign tif.run = running;
    assign tif.sel = byte_timer_control[CTRL_CLK_HI:CTRL_CLK_LO]; // RULE3

    btc_prescale u_prescale (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .tif    (tif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // counter core

    assign expire = mode_demod ? (count == COUNT_MAX) : (count == '0);
    assign timeout_ev = running && !stop_req && tif.tick && expire; // RULE14
    assign capture_ev = running && !stop_req && mode_demod && in_edge;

    always_comb begin
        next_state = state;
        next_count = count;
        next_out   = tmr_out;
        if (stop_req) begin
            next_state = BTC_STOPPED; // RULE1
        end else if (start_req) begin
            next_state = BTC_RUNNING; // RULE1
            next_out   = shared_timer_control[SHARED_INIT_OUT];
            if (mode_demod) begin
                next_count = '0;
            end else if (shared_timer_control[SHARED_INIT_OUT]) begin
                next_count = high_duration_load; // RULE11
            end else begin
                next_count = low_duration_load; // RULE13
            end
        end else if (running) begin
            if (capture_ev) begin
                // tick of the edge cycle already belongs to the new level
                next_count = {{(DATA_W-1){1'b0}}, tif.tick}; // RULE8 RULE9
            end else if (tif.tick && mode_demod) begin
                next_count = count + 1'b1;
                if (expire && single_pass) begin
                    next_state = BTC_STOPPED; // RULE2
                end
            end else if (tif.tick) begin
                if (expire) begin
                    // toggle and load the duration of the new level
                    next_out   = !tmr_out; // RULE14
                    next_count = tmr_out ? low_duration_load : high_duration_load; // RULE14
                    if (single_pass) begin
                        next_state = BTC_STOPPED; // RULE2
                    end
                end else begin
                    next_count = count - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state   <= BTC_STOPPED;
            count   <= '0;
            tmr_out <= 1'b0;
        end else if (ce) begin
            state   <= next_state;
            count   <= next_count;
            tmr_out <= next_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // capture registers

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            high_phase_capture <= CAP_RST; // RULE10
            low_phase_capture  <= CAP_RST; // RULE10
        end else if (ce && capture_ev) begin
            if (in_last) begin
                high_phase_capture <= count; // RULE8
            end else begin
                low_phase_capture <= count; // RULE9
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and request

    assign events = {capture_ev, timeout_ev};
    assign gate   = {byte_timer_control[CTRL_CAP_IE], byte_timer_control[CTRL_TO_IE]};
    assign next_irq = |(int_status & int_mask & gate); // RULE5 RULE6
    // clearing read drops only the bits it has reported
    assign status_ack = rd_status ? avs_readdata[INT_W-1:0] : {INT_W{1'b0}};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_status <= INT_RST;
            irq        <= 1'b0;
        end else if (ce) begin
            // new events survive the clearing read
            int_status <= (int_status & ~status_ack) | events;
            irq        <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin and timer outputs

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_out           <= 1'b0;
            pin_oe            <= 1'b0;
            byte_timer_output <= 1'b0;
        end else if (ce) begin
            pin_out           <= byte_timer_control[CTRL_PIN_ROUTE] ? tmr_out : gpio_out; // RULE7
            pin_oe            <= byte_timer_control[CTRL_PIN_ROUTE] || gpio_oe; // RULE7
            byte_timer_output <= tmr_out;
        end
    end

endmodule

// ===== verilog/btc_pkg.sv
// shared constants and types of the byte timer with capture and load
package btc_pkg;

    localparam int DATA_W = 8;
    localparam int BUS_W  = 32;
    localparam int ADDR_W = 6;
    localparam int IDX_W  = 4;

    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CTRL       = 4'h0;
    localparam logic [IDX_W-1:0] IDX_SHARED     = 4'h1;
    localparam logic [IDX_W-1:0] IDX_LOW_LOAD   = 4'h4;
    localparam logic [IDX_W-1:0] IDX_HIGH_LOAD  = 4'h5;
    localparam logic [IDX_W-1:0] IDX_LOW_CAP    = 4'hA;
    localparam logic [IDX_W-1:0] IDX_HIGH_CAP   = 4'hB;
    localparam logic [IDX_W-1:0] IDX_INT_STATUS = 4'hC;
    localparam logic [IDX_W-1:0] IDX_INT_MASK   = 4'hD;

    // control register fields
    localparam int CTRL_ENABLE    = 7;
    localparam int CTRL_SINGLE    = 6;
    localparam int CTRL_TIMEOUT   = 5;
    localparam int CTRL_CLK_HI    = 4;
    localparam int CTRL_CLK_LO    = 3;
    localparam int CTRL_CAP_IE    = 2;
    localparam int CTRL_TO_IE     = 1;
    localparam int CTRL_PIN_ROUTE = 0;

    // shared control fields
    localparam int SHARED_MODE     = 7;
    localparam int SHARED_INIT_OUT = 1;

    // interrupt status and mask fields
    localparam int INT_W       = 2;
    localparam int INT_TIMEOUT = 0;
    localparam int INT_CAPTURE = 1;

    // values after reset, counter top value and prescaler width
    localparam logic [DATA_W-1:0] CTRL_RST      = 8'h00;
    localparam logic [DATA_W-1:0] SHARED_RST    = 8'h00;
    localparam logic [DATA_W-1:0] LOAD_RST      = 8'h00;
    localparam logic [DATA_W-1:0] CAP_RST       = 8'h00;
    localparam logic [INT_W-1:0]  INT_RST       = 2'h0;
    localparam logic [DATA_W-1:0] COUNT_MAX     = 8'hFF;
    localparam int                PRESCALE_W    = 3;

    typedef enum logic {
        BTC_STOPPED,
        BTC_RUNNING
    } btc_state_t;

endpackage

// ===== verilog/btc_tick_if.sv
// tick request and answer between timer core and prescaler
interface btc_tick_if;
    logic       run;
    logic [1:0] sel;
    logic       tick;

    modport ctl (output run, output sel, input tick);
    modport div (input run, input sel, output tick);
endinterface

// ===== verilog/btc_prescale.sv
// system clock divider that makes the counting tick
module btc_prescale
    import btc_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    // tick carrier
    btc_tick_if.div   tif
);

    logic [PRESCALE_W-1:0] div_cnt;
    logic [PRESCALE_W-1:0] div_mask;

    // 00 none, 01 by 2, 10 by 4, 11 by 8
    assign div_mask = {tif.sel == 2'b11, tif.sel[1], |tif.sel}; // RULE3
    assign tif.tick = tif.run && ((div_cnt & div_mask) == div_mask); // RULE3

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt <= '0;
        end else if (ce) begin
            div_cnt <= tif.run ? div_cnt + 1'b1 : '0;
        end
    end

endmodule

// ===== bench/btc_timer_properties.sv
// port checker of the byte timer
module btc_timer_props
    import btc_pkg::*;
(
    // clock and reset
    input wire logic                      clk,
    input wire logic                      resetn,
    input wire logic                      ce,
    // register bus
    input wire logic                      avs_read,
    input wire logic                      avs_write,
    input wire logic [btc_pkg::BUS_W-1:0] avs_readdata,
    input wire logic                      avs_waitrequest,
    // pins and interrupt
    input wire logic                      gpio_out,
    input wire logic                      gpio_oe,
    input wire logic                      pin_out,
    input wire logic                      pin_oe,
    input wire logic                      byte_timer_output,
    input wire logic                      irq
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic req;
    logic      acc_done;
    assign req = avs_read || avs_write;
    // accepted transfer seen one edge ago
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_done <= 1'b0;
        end else begin
            acc_done <= req && !avs_waitrequest;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////
    a_wait_one: assert property (ce && req && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    a_wait_single: assert property (ce && !avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    a_wait_idle: assert property (ce && !req && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without request");
    a_data_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == '0)
        else $error("upper read data not zero");
    a_irq_clear: assert property ($fell(irq) |-> $past(acc_done))
        else $error("interrupt dropped without register access");
    a_reset_quiet: assert property ($rose(resetn) |-> avs_waitrequest && !irq && !pin_oe)
        else $error("outputs not at reset level");
    a_gpio_pass: assert property (!pin_oe |-> pin_out == $past(gpio_out))
        else $error("pin not following general drive");
    a_pin_timer: assert property (pin_oe && !$past(gpio_oe) |-> pin_out == byte_timer_output)
        else $error("pin not following timer output");
endmodule

bind btc_timer btc_timer_props i_btc_timer_props (.clk(clk), .resetn(resetn), .ce(ce),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .pin_out(pin_out), .pin_oe(pin_oe), .byte_timer_output(byte_timer_output), .irq(irq));

// ===== bench/btc_pulse_src.sv
// far side model: measured pulse source
module btc_pulse_src
(
    // clock and control
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic [7:0] hi_len,
    input  wire logic [7:0] lo_len,
    // measured signal
    output logic            pulse_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt = 8'h00;
    initial pulse_in = 1'b0;
    // alternate levels of the chosen lengths
    always @(posedge clk) begin
        if (!run) begin
            pulse_in <= 1'b0;
            cnt <= 8'h00;
        end else if (cnt == (pulse_in ? hi_len : lo_len) - 8'h01) begin
            pulse_in <= ~pulse_in;
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

// ===== bench/tb_top.sv
// self-checking bench of the byte timer
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import btc_pkg::*;
    logic              clk = 1'b0;
    logic              resetn = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [BUS_W-1:0]  avs_writedata = '0;
    logic [BUS_W-1:0]  avs_readdata;
    logic              avs_waitrequest;
    logic              pin_out;
    logic              pin_oe;
    logic              byte_timer_output;
    logic              irq;
    logic              pulse_in;
    logic              gpio_out = 1'b0;
    logic              src_run = 1'b0;
    logic [7:0]        q;
    logic [7:0]        h;
    int                err_total = 0;
    int                total_checks = 0;
    int                n;

    always #25 clk = ~clk;
    always @(posedge clk) if (resetn) gpio_out <= ~gpio_out;

    btc_timer i_btc_timer (.clk(clk), .resetn(resetn), .ce(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pulse_in(pulse_in),
        .gpio_out(gpio_out), .gpio_oe(1'b0), .pin_out(pin_out), .pin_oe(pin_oe),
        .byte_timer_output(byte_timer_output), .irq(irq));
    btc_pulse_src i_btc_pulse_src (.clk(clk), .run(src_run), .hi_len(8'h0A),
        .lo_len(8'h06), .pulse_in(pulse_in));
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_up();
        err_total++;
        $display("wrong value at %0t: wait ran out", $time);
        complete_run();
    endtask
    task automatic bus(input logic wr, input logic [IDX_W-1:0] i, input logic [7:0] d);
        int k;
        @(posedge clk);
        avs_address <= {i, 2'b00};
        avs_writedata <= {24'h000000, d};
        avs_write <= wr;
        avs_read <= ~wr;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) give_up();
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd(input logic [IDX_W-1:0] i);
        bus(1'b0, i, 8'h00);
    endtask
    task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d);
        bus(1'b1, i, d);
    endtask
    // length in cycles of the next full phase at level lvl
    task automatic level_time(input logic lvl, input int exp);
        int k;
        int m;
        k = 0;
        m = 0;
        while (byte_timer_output === lvl && k < 900) begin @(posedge clk); k++; end
        while (byte_timer_output !== lvl && k < 900) begin @(posedge clk); k++; end
        while (byte_timer_output === lvl && k < 900) begin @(posedge clk); k++; m++; end
        if (k >= 900) give_up();
        check(m[7:0], exp[7:0]);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(negedge clk);
        check({7'h00, irq}, {7'h00, e});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd(IDX_CTRL); check(q, CTRL_RST);
        rd(IDX_HIGH_CAP); check(q, CAP_RST);
        rd(IDX_LOW_CAP); check(q, CAP_RST);
        rd(IDX_HIGH_LOAD); check(q, LOAD_RST);
        wr(IDX_HIGH_LOAD, 8'hA5); rd(IDX_HIGH_LOAD); check(q, 8'hA5);
        rd(4'h7); check(q, 8'h00);
        // transmit waveform at every prescale
        wr(IDX_LOW_LOAD, 8'h02);
        wr(IDX_HIGH_LOAD, 8'h03);
        for (int s = 0; s < 4; s++) begin
            wr(IDX_CTRL, 8'h00);
            wr(IDX_CTRL, {3'b100, s[1:0], 3'b001});
            level_time(1'b1, 4 << s);
            level_time(1'b0, 3 << s);
            check({7'h00, pin_oe}, 8'h01);
        end
        rd(IDX_CTRL); check(q, 8'hB9);
        wr(IDX_CTRL, 8'h20); rd(IDX_CTRL); check(q, 8'h00);
        // single pass stops at first expiry
        wr(IDX_CTRL, 8'hC0);
        n = 0;
        do begin rd(IDX_CTRL); n++; end while (q[7] !== 1'b0 && n < 20);
        check(q, 8'h60);
        wr(IDX_CTRL, 8'h40); rd(IDX_CTRL); check(q, 8'h60);
        // interrupt gating and clearing
        irq_is(1'b0);
        wr(IDX_INT_MASK, 8'h03); irq_is(1'b0);
        wr(IDX_CTRL, 8'h42); irq_is(1'b1);
        wr(IDX_INT_MASK, 8'h02); irq_is(1'b0);
        wr(IDX_INT_MASK, 8'h03); irq_is(1'b1);
        rd(IDX_INT_STATUS); check(q, 8'h01);
        irq_is(1'b0);
        rd(IDX_INT_STATUS); check(q, 8'h00);
        // capture of both input phases
        wr(IDX_SHARED, 8'h80);
        src_run <= 1'b1;
        wr(IDX_CTRL, 8'h84);
        n = 0;
        do begin
            rd(IDX_HIGH_CAP);
            h = q;
            rd(IDX_LOW_CAP);
            n++;
        end while ((h !== 8'h0A || q !== 8'h06) && n < 30);
        check(h, 8'h0A);
        check(q, 8'h06);
        wr(IDX_HIGH_CAP, 8'h55); rd(IDX_HIGH_CAP); check(q, 8'h0A);
        irq_is(1'b1);
        wr(IDX_CTRL, 8'h80); irq_is(1'b0);
        complete_run();
    end
endmodule
